// ===== i2cm_pkg.sv
`default_nettype none
package i2cm_pkg;

  // ----------------------------------------------------------------
  // Register map (word addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam int          ADDR_W           = 3;
  localparam logic [2:0]  ADDR_RELOAD      = 3'h0;
  localparam logic [2:0]  ADDR_BUFFER      = 3'h1;
  localparam logic [2:0]  ADDR_CONTROL_TWO = 3'h2;
  localparam logic [2:0]  ADDR_STATUS      = 3'h3;

  // ----------------------------------------------------------------
  // Control-two fields
  // ----------------------------------------------------------------
  localparam int BIT_START   = 0;
  localparam int BIT_RECEIVE = 3;
  localparam int BIT_ACK_EN  = 4;
  localparam int BIT_ACK_VAL = 5;
  localparam int BIT_ACK_ST  = 6;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int BIT_FULL    = 0;
  localparam int BIT_START_S = 3;
  localparam int BIT_WRITE_COLLISION_FLAG    = 4;
  localparam int BIT_IRQ     = 5;
  localparam int BIT_BUSY    = 6;

  localparam logic [6:0] RELOAD_RESET = 7'h00;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } i2cm_bus_s;

  typedef struct packed {
    logic scl_i;
    logic sda_i;
  } i2cm_pin_in_s;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } i2cm_pin_out_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START_WAIT, ST_START_HOLD,
    ST_TX_LOW, ST_TX_HIGH, ST_RX_LOW, ST_RX_HIGH,
    ST_ACK_LOW, ST_ACK_HIGH
  } i2cm_state_e;

endpackage : i2cm_pkg
`default_nettype wire

// ===== i2cm_sync.sv
`default_nettype none
module i2cm_sync (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  // Raw pins
  input  wire i2cm_pkg::i2cm_pin_in_s pin_raw,
  // Synchronised pins
  output var  i2cm_pkg::i2cm_pin_in_s pin_sync
);
  import i2cm_pkg::*;

  typedef struct packed {
    i2cm_pin_in_s first;
    i2cm_pin_in_s second;
  } i2cm_sync_s;

  i2cm_sync_s state;
  i2cm_sync_s next_state;

  always_comb begin
    next_state.first  = pin_raw;
    next_state.second = state.first;
  end

  // Pulled-up lines idle high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '1;
    end else begin
      state <= next_state;
    end
  end

  assign pin_sync = state.second;

endmodule : i2cm_sync
`default_nettype wire

// ===== i2cm_phase.sv
`default_nettype none
module i2cm_phase (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Count strobe, second and fourth quarter of each instruction cycle
  output logic      count_tick
);
  import i2cm_pkg::*;

  // ----------------------------------------------------------------
  // Quarter-phase counter: four core clocks form one instruction cycle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] quarter;
  } i2cm_phase_s;

  i2cm_phase_s state;
  i2cm_phase_s next_state;

  always_comb begin
    next_state.quarter = state.quarter + 2'h1;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Quarters 1 and 3 are phase two and phase four
  assign count_tick = state.quarter[0];

endmodule : i2cm_phase
`default_nettype wire

// ===== i2cm_master.sv
`default_nettype none
module i2cm_master (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // Register port
  input  wire i2cm_pkg::i2cm_bus_s     bus,
  output logic [7:0]                   rdata,
  // Serial bus pins
  input  wire i2cm_pkg::i2cm_pin_in_s  pin_in,
  output var  i2cm_pkg::i2cm_pin_out_s pin_out,
  // Interrupt flag level
  output logic                         port_interrupt_flag
);
  import i2cm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    i2cm_state_e fsm;
    logic [6:0]  bitrate_reload_reg;
    logic [6:0]  bitrate_counter;
    logic        counting;
    logic [7:0]  shift_buffer_reg;
    logic [7:0]  shift_register;
    logic [3:0]  bit_count;
    logic        buffer_full_flag;
    logic        write_collision_flag;
    logic        ack_received_status;
    logic        ack_value_bit;
    logic        ack_sequence_enable;
    logic        receive_enable_bit;
    logic        start_enable_bit;
    logic        start_seen;
    logic        port_interrupt_flag;
    logic        scl_low;
    logic        sda_low;
    logic        receiving;
    logic [7:0]  rdata;
  } i2cm_master_s;

  i2cm_master_s state;
  i2cm_master_s next_state;
  i2cm_pin_in_s pin_sync;
  logic         count_tick;
  logic         timeout;
  logic         busy;
  logic         buf_wr;
  logic         ctl_wr;
  logic         stat_wr;

  // ----------------------------------------------------------------
  // Pin synchroniser and phase strobe
  // ----------------------------------------------------------------

  i2cm_sync u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin_raw  (pin_in),
    .pin_sync (pin_sync)
  );

  // Counter steps on two quarters of each instruction cycle
  i2cm_phase u_phase (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .count_tick (count_tick)
  );

  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  // Any running sequence counts as busy; commands are not queued
  assign busy    = (state.fsm != ST_IDLE);
  assign timeout = state.counting && count_tick && (state.bitrate_counter == RELOAD_RESET);
  assign buf_wr  = bus.wr && (bus.addr == ADDR_BUFFER);
  assign ctl_wr  = bus.wr && (bus.addr == ADDR_CONTROL_TWO);
  assign stat_wr = bus.wr && (bus.addr == ADDR_STATUS);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;

    // Bit-rate counter: decrement to zero, then stop
    if (state.counting && count_tick) begin
      if (state.bitrate_counter == RELOAD_RESET) begin
        next_state.counting = 1'b0;
      end else begin
        next_state.bitrate_counter = state.bitrate_counter - 7'h01;
      end
    end

    // Register writes
    // Bit 7 of the reload byte is ignored
    if (bus.wr && bus.addr == ADDR_RELOAD) begin
      next_state.bitrate_reload_reg = bus.wdata[6:0];
    end
    // Control writes while busy are dropped, not queued
    if (ctl_wr && !busy) begin
      next_state.ack_value_bit = bus.wdata[BIT_ACK_VAL];
      next_state.ack_sequence_enable = bus.wdata[BIT_ACK_EN];
      next_state.receive_enable_bit = bus.wdata[BIT_RECEIVE];
      next_state.start_enable_bit = bus.wdata[BIT_START];
    end
    if (stat_wr) begin
      // Software clears; only zero bits clear
      if (!bus.wdata[BIT_WRITE_COLLISION_FLAG]) next_state.write_collision_flag = 1'b0;
      if (!bus.wdata[BIT_IRQ]) next_state.port_interrupt_flag = 1'b0;
      if (!bus.wdata[BIT_START_S]) next_state.start_seen = 1'b0;
    end

    // Buffer write: accepted only when idle, else collision
    if (buf_wr) begin
      if (busy) begin
        next_state.write_collision_flag = 1'b1;
      end else begin
        next_state.shift_buffer_reg = bus.wdata;
        next_state.shift_register = bus.wdata;
        next_state.buffer_full_flag = 1'b1;
        next_state.bit_count = '0;
        next_state.receiving = 1'b0;
        next_state.bitrate_counter = state.bitrate_reload_reg;
        next_state.counting = 1'b1;
        next_state.scl_low = 1'b1;
        next_state.fsm = ST_TX_LOW;
      end
    end

    // Buffer read clears full in receive
    next_state.rdata = BYTE_ZERO;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_RELOAD: next_state.rdata = {1'b0, state.bitrate_reload_reg};
        ADDR_BUFFER: begin
          next_state.rdata = state.shift_buffer_reg;
          if (state.receiving) next_state.buffer_full_flag = 1'b0;
        end
        ADDR_CONTROL_TWO: begin
          next_state.rdata[BIT_ACK_ST] = state.ack_received_status;
          next_state.rdata[BIT_ACK_VAL] = state.ack_value_bit;
          next_state.rdata[BIT_ACK_EN] = state.ack_sequence_enable;
          next_state.rdata[BIT_RECEIVE] = state.receive_enable_bit;
          next_state.rdata[BIT_START] = state.start_enable_bit;
        end
        ADDR_STATUS: begin
          next_state.rdata[BIT_FULL] = state.buffer_full_flag;
          next_state.rdata[BIT_START_S] = state.start_seen;
          next_state.rdata[BIT_WRITE_COLLISION_FLAG] = state.write_collision_flag;
          next_state.rdata[BIT_IRQ] = state.port_interrupt_flag;
          next_state.rdata[BIT_BUSY] = busy;
        end
        default: next_state.rdata = BYTE_ZERO;
      endcase
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    case (state.fsm)
      // Start has priority over receive and acknowledge
      ST_IDLE: begin
        if (state.start_enable_bit) begin
          if (pin_sync.scl_i && pin_sync.sda_i) begin
            next_state.bitrate_counter = state.bitrate_reload_reg;
            next_state.counting = 1'b1;
            next_state.fsm = ST_START_WAIT;
          end
        end else if (state.receive_enable_bit) begin
          next_state.bitrate_counter = state.bitrate_reload_reg;
          next_state.counting = 1'b1;
          next_state.bit_count = '0;
          next_state.scl_low = 1'b1;
          next_state.sda_low = 1'b0;
          next_state.fsm = ST_RX_LOW;
        end else if (state.ack_sequence_enable) begin
          next_state.bitrate_counter = state.bitrate_reload_reg;
          next_state.counting = 1'b1;
          next_state.scl_low = 1'b1;
          next_state.sda_low = !state.ack_value_bit;
          next_state.fsm = ST_ACK_LOW;
        end
      end
      ST_START_WAIT: begin
        if (timeout) begin
          if (pin_sync.scl_i && pin_sync.sda_i) begin
            next_state.sda_low = 1'b1;
            next_state.start_seen = 1'b1;
            next_state.bitrate_counter = state.bitrate_reload_reg;
            next_state.counting = 1'b1;
            next_state.fsm = ST_START_HOLD;
          end else begin
            // Bus not free: retry after reload
            next_state.bitrate_counter = state.bitrate_reload_reg;
            next_state.counting = 1'b1;
          end
        end
      end
      ST_START_HOLD: begin
        // Second period keeps data low as the start hold time
        if (timeout) begin
          next_state.start_enable_bit = 1'b0;
          next_state.port_interrupt_flag = 1'b1;
          next_state.fsm = ST_IDLE;
        end
      end
      ST_TX_LOW, ST_RX_LOW, ST_ACK_LOW: begin
        if (timeout) begin
          next_state.scl_low = 1'b0;
          next_state.fsm = (state.fsm == ST_TX_LOW) ? ST_TX_HIGH :
                           (state.fsm == ST_RX_LOW) ? ST_RX_HIGH : ST_ACK_HIGH;
        end else if (state.fsm == ST_TX_LOW && state.counting) begin
          // Drive bit early in the low phase, after the fall
          if (state.bit_count < BITS_PER_BYTE) begin
            next_state.sda_low = !state.shift_register[7];
          end else begin
            next_state.sda_low = 1'b0;
          end
        end else if (state.fsm == ST_RX_LOW) begin
          next_state.sda_low = 1'b0;
        end
      end
      // High phase: counter held until the line reads high
      ST_TX_HIGH, ST_RX_HIGH, ST_ACK_HIGH: begin
        if (!state.counting && state.bitrate_counter == state.bitrate_reload_reg) begin
          // Waiting for clock release seen high
          if (pin_sync.scl_i) next_state.counting = 1'b1;
        end else if (!state.counting && !timeout &&
                     state.bitrate_counter != state.bitrate_reload_reg &&
                     state.bitrate_counter != RELOAD_RESET) begin
          next_state.counting = 1'b0;
        end
        if (state.scl_low == 1'b0 && !state.counting &&
            state.bitrate_counter == RELOAD_RESET) begin
          // Previous low phase ended; hold until clock sampled high
          next_state.bitrate_counter = state.bitrate_reload_reg;
        end
        if (timeout) begin
          next_state.scl_low = 1'b1;
          next_state.bitrate_counter = state.bitrate_reload_reg;
          next_state.counting = 1'b1;
          case (state.fsm)
            ST_TX_HIGH: begin
              next_state.bit_count = state.bit_count + 4'h1;
              next_state.shift_register = {state.shift_register[6:0], 1'b0};
              next_state.fsm = ST_TX_LOW;
              if (state.bit_count == BITS_PER_BYTE - 4'h1) begin
                next_state.buffer_full_flag = 1'b0;
                next_state.sda_low = 1'b0;
              end
              if (state.bit_count == BITS_PER_BYTE) begin
                next_state.ack_received_status = pin_sync.sda_i;
                next_state.port_interrupt_flag = 1'b1;
                next_state.counting = 1'b0;
                next_state.fsm = ST_IDLE;
              end
            end
            ST_RX_HIGH: begin
              // Data sampled at the end of the high phase
              next_state.shift_register = {state.shift_register[6:0], pin_sync.sda_i};
              next_state.bit_count = state.bit_count + 4'h1;
              next_state.fsm = ST_RX_LOW;
              if (state.bit_count == BITS_PER_BYTE - 4'h1) begin
                next_state.receive_enable_bit = 1'b0;
                next_state.shift_buffer_reg = {state.shift_register[6:0], pin_sync.sda_i};
                next_state.buffer_full_flag = 1'b1;
                next_state.port_interrupt_flag = 1'b1;
                next_state.receiving = 1'b1;
                next_state.counting = 1'b0;
                next_state.fsm = ST_IDLE;
              end
            end
            // Acknowledge sequence ends idle with the clock held low
            default: begin
              next_state.ack_sequence_enable = 1'b0;
              next_state.port_interrupt_flag = 1'b1;
              next_state.counting = 1'b0;
              next_state.fsm = ST_IDLE;
            end
          endcase
        end
      end
      default: next_state.fsm = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
      // Reads as not acknowledged until a byte ends
      state.ack_received_status <= 1'b1;
      state.fsm <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs: open drain, drive low or release
  // ----------------------------------------------------------------
  // Enables high pull the line low
  always_comb begin
    pin_out.scl_o  = 1'b0;
    pin_out.sda_o  = 1'b0;
    pin_out.scl_oe = state.scl_low;
    pin_out.sda_oe = state.sda_low;
  end

  assign rdata = state.rdata;
  assign port_interrupt_flag = state.port_interrupt_flag;

endmodule : i2cm_master
`default_nettype wire

// ===== i2cm_properties.sv
`default_nettype none
module i2cm_properties (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  // Observed top-level ports
  input  wire i2cm_pkg::i2cm_bus_s     bus,
  input  wire logic [7:0]             rdata,
  input  wire i2cm_pkg::i2cm_pin_in_s  pin_in,
  input  wire i2cm_pkg::i2cm_pin_out_s pin_out,
  input  wire logic                   port_interrupt_flag
);
  import i2cm_pkg::*;
  // ------------------------------------------------------------
  // Helper: reload copy and released-high cycle count
  // ------------------------------------------------------------
  logic [6:0]      reload;
  logic [8:0]      hi_cnt;
  logic            hi_ok;
  wire logic [8:0] hi_min = {1'b0, reload, 1'b0} + 9'h002;
  wire logic [8:0] hi_max = {1'b0, reload, 1'b0} + 9'h008;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reload <= RELOAD_RESET;
      hi_cnt <= 9'h000;
      hi_ok  <= 1'b0;
    end else begin
      if (bus.wr && bus.addr == ADDR_RELOAD) reload <= bus.wdata[6:0];
      if ($fell(pin_out.scl_oe)) begin
        hi_cnt <= 9'h000;
        hi_ok  <= 1'b1;
      end else if ($rose(pin_out.scl_oe)) begin
        hi_ok  <= 1'b0;
      end else if (pin_in.scl_i && !pin_out.scl_oe && hi_cnt != 9'h1FF) begin
        hi_cnt <= hi_cnt + 9'h001;
      end
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_scl_drop;
    $rose(pin_out.scl_oe) ##0 hi_ok;
  endsequence
  sequence s_start_edge;
    $rose(pin_out.sda_oe) ##0 !pin_out.scl_oe;
  endsequence
  a_open_drain:
    assert property (!pin_out.scl_o && !pin_out.sda_o) else $error("bus line driven high");
  a_rdata_idle:
    assert property (!$past(bus.rd) |-> rdata == BYTE_ZERO) else $error("stray read data");
  a_status_irq_view:
    assert property (bus.rd && bus.addr == ADDR_STATUS |=> rdata[BIT_IRQ] == $past(port_interrupt_flag))
    else $error("status read misses flag");
  a_irq_clear:
    assert property (bus.wr && bus.addr == ADDR_STATUS && !bus.wdata[BIT_IRQ] |=>
      !port_interrupt_flag) else $error("flag not cleared");
  a_start_form:
    assert property (s_start_edge |-> $past(pin_in.scl_i) && $past(pin_in.sda_i))
    else $error("start without idle lines");
  a_sda_steady_high:
    assert property (!pin_out.scl_oe && !$past(pin_out.scl_oe) |-> !$fell(pin_out.sda_oe))
    else $error("data moved while clock high");
  a_scl_hold_low:
    assert property (port_interrupt_flag && pin_out.scl_oe && !bus.wr && !$past(bus.wr) |=>
      pin_out.scl_oe && $stable(pin_out.sda_oe)) else $error("clock not held low");
  a_start_sda_hold:
    assert property (port_interrupt_flag && pin_out.sda_oe && !pin_out.scl_oe && !bus.wr |=>
      pin_out.sda_oe) else $error("data released after start");
  a_scl_high_time:
    assert property (s_scl_drop |-> hi_cnt >= hi_min && hi_cnt <= hi_max)
    else $error("clock high time off");
endmodule : i2cm_properties

bind i2cm_master i2cm_properties i2cm_properties_inst (
  .core_clk            (core_clk),
  .rst_b               (rst_b),
  .bus                 (bus),
  .rdata               (rdata),
  .pin_in              (pin_in),
  .pin_out             (pin_out),
  .port_interrupt_flag (port_interrupt_flag)
);
`default_nettype wire

// ===== i2cm_slave_model.sv
`default_nettype none
module i2cm_slave_model (
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            scl_oe,
  output logic            sda_oe,
  // Bench controls
  input  wire logic       send,
  input  wire logic [7:0] tx_byte,
  input  wire logic       ack_on,
  input  wire logic       stretch,
  // Observations
  output logic [7:0]      rx_byte,
  output logic [7:0]      starts
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;
  initial begin
    scl_oe  = 1'b0;
    sda_oe  = 1'b0;
    rx_byte = 8'h00;
    starts  = 8'h00;
    n       = 0;
  end
  // Data falling under a high clock opens a frame
  always @(negedge sda) begin
    if (scl) begin
      starts <= starts + 8'h01;
      // The master's first clock fall opens bit zero
      n = -1;
    end
  end
  always @(posedge scl) begin
    if (n < 8) rx_byte <= {rx_byte[6:0], sda};
  end
  always @(posedge send) sda_oe <= !tx_byte[7];
  // Nine clocks to a frame either way
  always @(negedge scl) begin
    n = (n == 8) ? 0 : n + 1;
    if (send) sda_oe <= (n < 8) && !tx_byte[7 - n];
    else sda_oe <= ack_on && (n == 8);
    if (stretch) begin
      scl_oe = 1'b1;
      #300;
      scl_oe = 1'b0;
    end
  end
endmodule : i2cm_slave_model
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb;
  import i2cm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Wiring, with pull-ups on both lines
  // ------------------------------------------------------------
  logic              core_clk, rst_b, irq, rd_q;
  logic              s_scl_oe, s_sda_oe, send, ack_on, stretch;
  i2cm_bus_s         bus;
  i2cm_pin_out_s     pin_out;
  logic [7:0]        rdata, tx_byte, rx_byte, starts, b;
  logic [7:0]        exp_q[$];
  int                bad_count, check_count, cyc;
  wire logic         scl = !(pin_out.scl_oe || s_scl_oe);
  wire logic         sda = !(pin_out.sda_oe || s_sda_oe);
  wire i2cm_pin_in_s pin_in = {scl, sda};
  i2cm_master i2cm_master_inst (
    .core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .port_interrupt_flag(irq));
  i2cm_slave_model i2cm_slave_model_inst (
    .scl(scl), .sda(sda), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .send(send),
    .tx_byte(tx_byte), .ack_on(ack_on), .stretch(stretch), .rx_byte(rx_byte), .starts(starts));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
  endtask : rd
  task automatic wait_irq();
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge core_clk);
    chk({7'h00, irq}, 8'h01);
    @(posedge core_clk);
  endtask : wait_irq
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  // ------------------------------------------------------------
  // Clock, read-data watcher, hang guard
  // ------------------------------------------------------------
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    rd_q <= bus.rd;
    if (rd_q) chk(rdata, exp_q.pop_front());
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("unexpected at %0t: run did not finish", $time);
      final_report();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    bus = '0;
    {send, ack_on, stretch, rd_q, tx_byte} = '0;
    {bad_count, check_count, cyc} = '0;
    void'($urandom(32'hA1EBC8A0));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(ADDR_CONTROL_TWO, 8'h40);
    rd(ADDR_STATUS, 8'h00);
    rd(3'h7, 8'h00);
    wr(ADDR_RELOAD, 8'h83);
    rd(ADDR_RELOAD, 8'h03);
    wr(ADDR_CONTROL_TWO, 8'h01);
    wr(ADDR_BUFFER, 8'h5A);
    wait_irq();
    chk(starts, 8'h01);
    chk({7'h00, sda}, 8'h00);
    rd(ADDR_CONTROL_TWO, 8'h40);
    rd(ADDR_STATUS, 8'h38);
    rd(ADDR_BUFFER, 8'h00);
    wr(ADDR_STATUS, 8'h00);
    for (int k = 0; k < 2; k++) begin
      b = (k == 0) ? {7'($urandom), 1'b0} : 8'($urandom);
      ack_on <= (k == 0);
      stretch <= (k == 1);
      wr(ADDR_BUFFER, b);
      rd(ADDR_STATUS, 8'h41);
      wr(ADDR_BUFFER, ~b);
      wait_irq();
      chk(rx_byte, b);
      chk({7'h00, scl}, 8'h00);
      rd(ADDR_CONTROL_TWO, (k == 0) ? 8'h00 : 8'h40);
      rd(ADDR_STATUS, 8'h30);
      rd(ADDR_BUFFER, b);
      wr(ADDR_STATUS, 8'h00);
    end
    b = 8'($urandom);
    tx_byte <= b;
    send <= 1'b1;
    stretch <= 1'b0;
    @(posedge core_clk);
    wr(ADDR_CONTROL_TWO, 8'h08);
    wr(ADDR_BUFFER, ~b);
    wait_irq();
    send <= 1'b0;
    rd(ADDR_CONTROL_TWO, 8'h40);
    rd(ADDR_STATUS, 8'h31);
    rd(ADDR_BUFFER, b);
    rd(ADDR_STATUS, 8'h30);
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_CONTROL_TWO, 8'h10);
    wait_irq();
    rd(ADDR_CONTROL_TWO, 8'h40);
    repeat (4) @(posedge core_clk);
    final_report();
  end
endmodule : tb
`default_nettype wire
